//--- verilog/cdrf_regs.v
// Dedicated register file with flags, bank pointer and AXI4-Lite access.
//
// Behaviour
// - Instruction pointer, sixteen bits, resets to FFFD.
// - Main accumulator sixteen bits; byte ops use low.
// - Temporary accumulator second operand; byte ops low.
// - Index, extra, stack pointers undefined after reset.
// - Status word: bank pointer high, flags low.
// - Reset clears enable, sets level mask 11.
// - Half carry from bit three into four.
// - Interrupts accepted only while enable is set.
// - Service only levels above mask; 11 blocks.
// - Negative flag copies result most significant bit.
// - Zero flag set when result equals zero.
// - Overflow flag on two's complement overflow.
// - Carry flag on carry or borrow out of bit seven; word ops here take it from bit fifteen.
// - Shifts load carry with the shifted-out bit.
// - Eight registers per bank, 32 banks, selected.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "cdrf_map.vh"

module cdrf_regs #(
    parameter BANKS = 32,
    parameter REGS_PER_BANK = 8
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // AXI4-Lite write address and data.
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read.
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Datapath: arithmetic step and register loads.
    input  wire [2:0]  alu_op,
    input  wire        alu_word,
    input  wire [3:0]  flag_affect,
    input  wire        ip_load,
    input  wire [15:0] ip_value,
    input  wire        ip_step,
    // Interrupt admission.
    input  wire        irq_req,
    input  wire [1:0]  irq_level,
    output wire        irq_accept,
    // Register bank access.
    input  wire [2:0]  gpr_index,
    input  wire        gpr_we,
    input  wire [7:0]  gpr_wdata,
    output wire [7:0]  gpr_rdata,
    // Register views.
    output reg  [15:0] instruction_pointer,
    output reg  [15:0] main_accumulator,
    output reg  [15:0] program_state_word
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    reg [15:0] temporary_accumulator;
    reg [15:0] offset_base_reg;
    reg [15:0] extra_memory_pointer;
    reg [15:0] stack_top_pointer;
    reg [7:0]  gpr_mem [0:BANKS*REGS_PER_BANK-1];
    reg        alu_seen_q;

    wire [7:0] bank_select_pointer  = program_state_word[15:8];
    wire [7:0] condition_flags_byte = program_state_word[7:0];
    wire [1:0] interrupt_level_mask = condition_flags_byte[`CDRF_F_ILM_HI:`CDRF_F_ILM_LO];

    // The bank pointer field is eight bits; only its low five are used, so the top bits only wrap the index.
    function [7:0] gpr_addr;
        input [7:0] bank;
        input [2:0] idx;
        begin
            gpr_addr = {bank[4:0], idx};
        end
    endfunction

    wire [7:0] gpr_sel = gpr_addr(bank_select_pointer, gpr_index);
    assign gpr_rdata = gpr_mem[gpr_sel];

    ////////////////////////////////////////////////////////////////////////
    // Interrupt admission: levels 00 and 01 are both level 1.

    function [1:0] level_of;
        input [1:0] code;
        begin
            level_of = (code == 2'h0) ? 2'h1 : code;
        end
    endfunction

    // Lower level number is higher priority; a request at level 11 is never above any mask.
    assign irq_accept = irq_req & condition_flags_byte[`CDRF_F_IE]
        & (level_of(irq_level) < level_of(interrupt_level_mask));

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic on accumulator and temporary accumulator.

    wire [15:0] opa = alu_word ? main_accumulator      : {8'h00, main_accumulator[7:0]};
    wire [15:0] opb = alu_word ? temporary_accumulator : {8'h00, temporary_accumulator[7:0]};
    reg  [16:0] sum;
    reg  [4:0]  nib;
    reg  [8:0]  low9;
    reg  [15:0] res;
    reg         f_c;
    reg         f_h;
    reg         f_v;
    reg         f_n;
    reg         msb_a;
    reg         msb_b;
    reg         msb_r;

    always @*
    begin
        sum   = 17'h0_0000;
        nib   = 5'h00;
        low9  = 9'h000;
        res   = main_accumulator;
        f_c   = condition_flags_byte[`CDRF_F_C];
        f_h   = condition_flags_byte[`CDRF_F_H];
        f_v   = condition_flags_byte[`CDRF_F_V];
        case (alu_op)
            `CDRF_OP_ADD:
            begin
                sum  = {1'b0, opa} + {1'b0, opb};
                nib  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
                low9 = {1'b0, opa[7:0]} + {1'b0, opb[7:0]};
                res  = sum[15:0];
                f_h  = nib[4];
                f_c  = alu_word ? sum[16] : low9[8];
            end
            `CDRF_OP_SUB:
            begin
                sum  = {1'b0, opa} - {1'b0, opb};
                nib  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
                low9 = {1'b0, opa[7:0]} - {1'b0, opb[7:0]};
                res  = sum[15:0];
                f_h  = nib[4];
                f_c  = alu_word ? sum[16] : low9[8];
            end
            `CDRF_OP_SHL:
            begin
                res = alu_word ? {opa[14:0], 1'b0} : {8'h00, opa[6:0], 1'b0};
                f_c = alu_word ? opa[15] : opa[7];
            end
            `CDRF_OP_SHR:
            begin
                res = alu_word ? {1'b0, opa[15:1]} : {9'h000, opa[7:1]};
                f_c = opa[0];
            end
            default:
            begin
                res = main_accumulator;
            end
        endcase
        msb_a = alu_word ? opa[15] : opa[7];
        msb_b = alu_word ? opb[15] : opb[7];
        msb_r = alu_word ? res[15] : res[7];
        f_n   = msb_r;
        if (alu_op == `CDRF_OP_ADD)
            f_v = (msb_a == msb_b) & (msb_r != msb_a);
        else if (alu_op == `CDRF_OP_SUB)
            f_v = (msb_a != msb_b) & (msb_r != msb_a);
    end

    wire        alu_on  = (alu_op != `CDRF_OP_NONE);
    wire        res_zero = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
    wire        is_shift = (alu_op == `CDRF_OP_SHL) | (alu_op == `CDRF_OP_SHR);

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read at a time.

    reg        aw_held_q;
    reg [7:0]  aw_addr_q;
    reg        w_held_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire        aw_fire = s_axi_awvalid & s_axi_awready;
    wire        w_fire  = s_axi_wvalid & s_axi_wready;
    wire        aw_have = aw_held_q | aw_fire;
    wire        w_have  = w_held_q | w_fire;
    wire [7:0]  wa      = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wd      = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0]  ws      = w_held_q ? w_strb_q : s_axi_wstrb;
    wire        wr_go   = aw_have & w_have & ~s_axi_bvalid;

    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = (addr[1:0] == 2'b00) && (addr <= `CDRF_OFF_PSW);
        end
    endfunction

    // Byte-lane merge for the low halfword; upper lanes are ignored.
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    wire wr_ip  = wr_go & (wa == `CDRF_OFF_IP);
    wire wr_acc = wr_go & (wa == `CDRF_OFF_ACC);
    wire wr_tmp = wr_go & (wa == `CDRF_OFF_TMP);
    wire wr_obr = wr_go & (wa == `CDRF_OFF_OBR);
    wire wr_emp = wr_go & (wa == `CDRF_OFF_EMP);
    wire wr_stp = wr_go & (wa == `CDRF_OFF_STP);
    wire wr_psw = wr_go & (wa == `CDRF_OFF_PSW);

    always @(posedge clk)
    begin
        if (rst)
        begin
            aw_held_q    <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_held_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CDRF_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `CDRF_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (wr_go)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit(wa) ? `CDRF_RESP_OKAY : `CDRF_RESP_SLVERR;
            end
            else
            begin
                if (aw_fire)
                begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_fire)
                begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `CDRF_RESP_OKAY;
                case (s_axi_araddr)
                    `CDRF_OFF_IP:   s_axi_rdata <= {16'h0000, instruction_pointer};
                    `CDRF_OFF_ACC:  s_axi_rdata <= {16'h0000, main_accumulator};
                    `CDRF_OFF_TMP:  s_axi_rdata <= {16'h0000, temporary_accumulator};
                    `CDRF_OFF_OBR:  s_axi_rdata <= {16'h0000, offset_base_reg};
                    `CDRF_OFF_EMP:  s_axi_rdata <= {16'h0000, extra_memory_pointer};
                    `CDRF_OFF_STP:  s_axi_rdata <= {16'h0000, stack_top_pointer};
                    `CDRF_OFF_PSW:  s_axi_rdata <= {16'h0000, program_state_word};
                    `CDRF_OFF_STAT: s_axi_rdata <= {30'h0000_0000, alu_seen_q, irq_accept};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `CDRF_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dedicated registers. Bus writes win over datapath updates in the same cycle.

    always @(posedge clk)
    begin
        if (rst)
        begin
            instruction_pointer <= `CDRF_IP_RST;
            // Only enable and mask have reset values; the rest are cleared for
            // determinism, which software must not rely on.
            program_state_word  <= {8'h00, 1'b0, 1'b0, `CDRF_ILM_RST, 4'h0};
            alu_seen_q          <= 1'b0;
        end
        else
        begin
            if (wr_ip)
                instruction_pointer <= merge16(instruction_pointer, wd, ws);
            else if (ip_load)
                instruction_pointer <= ip_value;
            else if (ip_step)
                instruction_pointer <= instruction_pointer + 16'h0001;
            if (alu_on)
                alu_seen_q <= 1'b1;
            if (wr_psw)
                program_state_word <= merge16(program_state_word, wd, ws);
            else if (alu_on)
            begin
                // Each flag moves only when the instruction marks it affected; carry also moves on every shift.
                if (flag_affect[0] | is_shift)
                    program_state_word[`CDRF_F_C] <= f_c;
                if (flag_affect[1])
                    program_state_word[`CDRF_F_V] <= f_v;
                if (flag_affect[2])
                    program_state_word[`CDRF_F_Z] <= res_zero;
                if (flag_affect[3])
                    program_state_word[`CDRF_F_N] <= f_n;
                if (flag_affect[0])
                    program_state_word[`CDRF_F_H] <= f_h;
            end
        end
    end

    // No reset on these: their contents are undefined until written.
    always @(posedge clk)
    begin
        if (wr_acc)
            main_accumulator <= merge16(main_accumulator, wd, ws);
        else if (alu_on)
            main_accumulator <= alu_word ? res : {main_accumulator[15:8], res[7:0]};
        if (wr_tmp)
            temporary_accumulator <= merge16(temporary_accumulator, wd, ws);
        if (wr_obr)
            offset_base_reg <= merge16(offset_base_reg, wd, ws);
        if (wr_emp)
            extra_memory_pointer <= merge16(extra_memory_pointer, wd, ws);
        if (wr_stp)
            stack_top_pointer <= merge16(stack_top_pointer, wd, ws);
        if (gpr_we)
            gpr_mem[gpr_sel] <= gpr_wdata;
    end

endmodule // cdrf_regs

//--- common/cdrf_map.vh
// Register offsets, field positions and reset values of the dedicated register file.
`ifndef CDRF_MAP_VH
`define CDRF_MAP_VH

`define CDRF_OFF_IP        8'h00
`define CDRF_OFF_ACC       8'h04
`define CDRF_OFF_TMP       8'h08
`define CDRF_OFF_OBR       8'h0c
`define CDRF_OFF_EMP       8'h10
`define CDRF_OFF_STP       8'h14
`define CDRF_OFF_PSW       8'h18
`define CDRF_OFF_STAT      8'h1c

`define CDRF_IP_RST        16'hfffd
`define CDRF_ILM_RST       2'h3

`define CDRF_F_C           0
`define CDRF_F_V           1
`define CDRF_F_Z           2
`define CDRF_F_N           3
`define CDRF_F_ILM_LO      4
`define CDRF_F_ILM_HI      5
`define CDRF_F_IE          6
`define CDRF_F_H           7

`define CDRF_OP_NONE       3'h0
`define CDRF_OP_ADD        3'h1
`define CDRF_OP_SUB        3'h2
`define CDRF_OP_SHL        3'h3
`define CDRF_OP_SHR        3'h4

`define CDRF_RESP_OKAY     2'h0
`define CDRF_RESP_SLVERR   2'h2

`endif

//--- tb/cdrf_regs_chk.sv
// Concurrent checks on the ports of the dedicated register file.
`timescale 1ns/100ps
`include "cdrf_map.vh"

module cdrf_regs_chk (
    // Clock and reset.
    input wire        clk,
    input wire        rst,
    // Inputs seen by the block.
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire [2:0]  alu_op,
    input wire        alu_word,
    input wire [3:0]  flag_affect,
    input wire        irq_req,
    input wire [1:0]  irq_level,
    // Block outputs.
    input wire        irq_accept,
    input wire [15:0] instruction_pointer,
    input wire [15:0] main_accumulator,
    input wire [15:0] program_state_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A bus write in flight may win over the datapath, so flag checks wait for a quiet bus.
    wire quiet = !s_axi_awvalid && !s_axi_wvalid;
    wire arith = (alu_op == `CDRF_OP_ADD) || (alu_op == `CDRF_OP_SUB);

    function automatic [1:0] lvl(input [1:0] code);
        lvl = (code == 2'h0) ? 2'h1 : code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    ip_reset_a: assert property ($past(rst) |-> instruction_pointer == `CDRF_IP_RST)
        else $error("instruction pointer not at reset value");
    psw_reset_a: assert property ($past(rst) |-> program_state_word[6:4] == 3'h3)
        else $error("enable or level mask wrong after reset");
    irq_enable_a: assert property (!program_state_word[6] |-> !irq_accept)
        else $error("interrupt accepted while disabled");
    irq_level_a: assert property (irq_accept == (irq_req && program_state_word[6]
        && lvl(irq_level) < lvl(program_state_word[5:4])))
        else $error("interrupt admission does not follow the level mask");
    zero_flag_a: assert property (arith && flag_affect[2] && quiet |=>
        program_state_word[2] == (alu_word ? main_accumulator == 16'h0
        : main_accumulator[7:0] == 8'h0))
        else $error("zero flag does not match result");
    neg_flag_a: assert property (arith && flag_affect[3] && quiet |=>
        program_state_word[3] == (alu_word ? main_accumulator[15] : main_accumulator[7]))
        else $error("negative flag does not match result");
    high_kept_a: assert property (alu_op != `CDRF_OP_NONE && !alu_word && quiet |=>
        main_accumulator[15:8] == $past(main_accumulator[15:8]))
        else $error("byte operation changed the accumulator high byte");
    shift_out_a: assert property (alu_op == `CDRF_OP_SHR && quiet |=>
        program_state_word[0] == $past(main_accumulator[0]))
        else $error("carry is not the bit shifted out");
    flag_keep_a: assert property (alu_op != `CDRF_OP_NONE && flag_affect[3:1] == 3'h0
        && quiet |=> $stable(program_state_word[6:1]))
        else $error("unaffected flag changed");
endmodule // cdrf_regs_chk

bind cdrf_regs cdrf_regs_chk i_chk (.clk, .rst, .s_axi_awvalid, .s_axi_wvalid, .alu_op,
    .alu_word, .flag_affect, .irq_req, .irq_level, .irq_accept, .instruction_pointer,
    .main_accumulator, .program_state_word);

//--- tb/cdrf_regs_bench.sv
// Self-checking bench for the dedicated register file with flags.
`timescale 1ns/100ps
`include "cdrf_map.vh"

module cdrf_regs_bench;
    reg         clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg         alu_word, ip_load, ip_step, irq_req, gpr_we;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr, gpr_wdata;
    reg  [31:0] s_axi_wdata, rd;
    reg  [3:0]  s_axi_wstrb, flag_affect;
    reg  [2:0]  alu_op, gpr_index;
    reg  [15:0] ip_value;
    reg  [1:0]  irq_level, rsp;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_accept;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  gpr_rdata;
    wire [15:0] instruction_pointer, main_accumulator, program_state_word;
    integer     errors, checks, seed, i, j, k, a, t, ps, op, fa, w, nb, m, x, y, r, c, h, v, sa, sb;

    always #5 clk = ~clk;

    cdrf_regs i_cdrf_regs (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .alu_op, .alu_word, .flag_affect, .ip_load, .ip_value, .ip_step, .irq_req,
        .irq_level, .irq_accept, .gpr_index, .gpr_we, .gpr_wdata, .gpr_rdata, .instruction_pointer,
        .main_accumulator, .program_state_word);

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task end_sim;
        begin
            if (errors == 0 && checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task give_up(input integer n);
        begin
            if (n == 100)
            begin
                errors = errors + 1;
                end_sim;
            end
        end
    endtask

    // Ready is sampled at the falling edge; it only moves on rising edges, so it equals
    // the value the slave shows at the next rising edge.
    task axi_wr(input [7:0] ad, input [31:0] dt, output [1:0] re);
        reg     pa, pw, pb;
        integer n;
        begin
            s_axi_awaddr <= ad;
            s_axi_wdata <= dt;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            pb = 1'b0;
            for (n = 0; !pb; n = n + 1)
            begin
                give_up(n);
                @(negedge clk);
                pa = s_axi_awvalid & s_axi_awready;
                pw = s_axi_wvalid & s_axi_wready;
                pb = s_axi_bvalid;
                re = s_axi_bresp;
                @(posedge clk);
                if (pa) s_axi_awvalid <= 1'b0;
                if (pw) s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            // Let one edge pass so that the next request does not rewrite bready now.
            @(posedge clk);
        end
    endtask

    task axi_rd(input [7:0] ad, input [31:0] exp, input [1:0] er);
        reg     pa, pb;
        integer n;
        begin
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            pb = 1'b0;
            for (n = 0; !pb; n = n + 1)
            begin
                give_up(n);
                @(negedge clk);
                pa = s_axi_arvalid & s_axi_arready;
                pb = s_axi_rvalid;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                @(posedge clk);
                if (pa) s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            @(posedge clk);
            chk("rdata", rd, exp);
            chk("rresp", rsp, er);
        end
    endtask

    task do_reset(input integer n);
        begin
            rst <= 1'b1;
            repeat (n) @(posedge clk);
            rst <= 1'b0;
            axi_rd(8'h00, 32'h0000_fffd, `CDRF_RESP_OKAY);
            axi_rd(8'h18, 32'h0000_0030, `CDRF_RESP_OKAY);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        errors = 0;
        checks = 0;
        seed = 32'h7420_0a45;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {alu_word, ip_load, ip_step, irq_req, gpr_we, irq_level} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alu_op, gpr_index, ip_value, gpr_wdata} = '0;
        flag_affect = 4'h0;
        do_reset(10);
        for (i = 0; i < 7; i = i + 1)
        begin
            a = $random(seed) & 32'hffff_1fff;
            axi_wr(i * 4, a, rsp);
            chk("wresp", rsp, `CDRF_RESP_OKAY);
            axi_rd(i * 4, a & 32'h0000_ffff, `CDRF_RESP_OKAY);
        end
        axi_wr(8'h1c, 32'h0000_0001, rsp);
        chk("wresp", rsp, `CDRF_RESP_SLVERR);
        axi_rd(8'h20, 32'h0000_0000, `CDRF_RESP_SLVERR);
        // Every operation in both widths against a model of the flags.
        for (k = 0; k < 200; k = k + 1)
        begin
            a = $random(seed) & 16'hffff;
            t = $random(seed) & 16'hffff;
            ps = $random(seed) & 16'h1fff;
            fa = $random(seed) & 15;
            op = k % 4 + 1;
            w = (k / 4) % 2;
            axi_wr(8'h04, a, rsp);
            axi_wr(8'h08, t, rsp);
            axi_wr(8'h18, ps, rsp);
            alu_op <= op;
            alu_word <= w;
            flag_affect <= fa;
            @(posedge clk);
            alu_op <= `CDRF_OP_NONE;
            nb = w ? 16 : 8;
            m = (1 << nb) - 1;
            x = a & m;
            y = t & m;
            r = (op == 1) ? x + y : (op == 2) ? x - y : (op == 3) ? x << 1 : x >> 1;
            c = (op == 4) ? x & 1 : (r >> nb) & 1;
            h = ((op == 2) ? (x & 15) - (y & 15) : (x & 15) + (y & 15)) >> 4 & 1;
            sa = x >> (nb - 1);
            sb = y >> (nb - 1);
            v = (((r >> (nb - 1)) & 1) != sa) && ((op == 1) == (sa == sb));
            r = r & m;
            if (fa & 1 || op > 2) ps = ps & 16'hfffe | c;
            if (fa & 1) ps = ps & 16'hff7f | h << 7;
            if (fa & 2) ps = ps & 16'hfffd | v << 1;
            if (fa & 4) ps = ps & 16'hfffb | (r == 0) << 2;
            if (fa & 8) ps = ps & 16'hfff7 | (r >> (nb - 1)) << 3;
            // Half carry and overflow of a shift are left open, so they are not compared.
            m = (op > 2) ? 16'hff7d : 16'hffff;
            @(negedge clk);
            chk("acc", main_accumulator, w ? r : (a & 16'hff00) | r);
            chk("psw_hvc", program_state_word & m & 16'h0083, ps & m & 16'h0083);
            chk("psw_nz", program_state_word & 16'hff7c, ps & 16'hff7c);
            // Requests start only just after a rising edge.
            @(posedge clk);
        end
        irq_req <= 1'b1;
        for (i = 0; i < 32; i = i + 1)
        begin
            axi_wr(8'h18, (i >> 4) << 6 | (i & 3) << 4, rsp);
            irq_level <= (i >> 2) & 3;
            j = (i & 3) ? (i & 3) : 1;
            k = (i & 12) ? (i >> 2) & 3 : 1;
            @(negedge clk);
            chk("irq", irq_accept, (i >> 4) && k < j);
            @(posedge clk);
        end
        // Enabled, mask level 2, request level 1: admitted, seen through the status register at 0x1c.
        axi_wr(8'h18, 32'h0000_0060, rsp);
        irq_level <= 2'h0;
        axi_rd(8'h1c, 32'h0000_0003, `CDRF_RESP_OKAY);
        irq_req <= 1'b0;
        for (j = 0; j < 32; j = j + 1)
        begin
            i = j & 15;
            if ((i & 7) == 0) axi_wr(8'h18, (i & 8) ? 32'h0000_1f00 : 32'h0000_0000, rsp);
            gpr_index <= i & 7;
            gpr_wdata <= i * 17;
            gpr_we <= j < 16;
            @(posedge clk);
            gpr_we <= 1'b0;
            @(negedge clk);
            if (j > 15) chk("gpr", gpr_rdata, (i * 17) & 255);
            @(posedge clk);
        end
        ps = $random(seed) & 16'hffff;
        ip_value <= ps;
        ip_load <= 1'b1;
        ip_step <= 1'b1;
        @(posedge clk);
        ip_load <= 1'b0;
        @(posedge clk);
        ip_step <= 1'b0;
        @(negedge clk);
        chk("ip", instruction_pointer, (ps + 1) & 16'hffff);
        @(posedge clk);
        do_reset(2);
        end_sim;
    end
endmodule // cdrf_regs_bench
